// ===== fcc_chan.sv
// One sixteen-bit up/down counter with reload on over- or underflow.
`timescale 1ns/1ps
module fcc_chan #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic step,
  input wire logic up,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] reload_val,
  // Results
  output logic [W-1:0] count,
  output logic carry
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } fcc_chan_s;
  fcc_chan_s q, d;

  assign count = q.cnt;
  // Carry is combinational so a chain of channels steps in the same cycle.
  assign carry = step && (up ? (&q.cnt) : (q.cnt == '0));

  always_comb
  begin
    d = q;
    if (load)
      d.cnt = load_val;
    else if (carry)
      d.cnt = reload_val;
    else if (step)
      d.cnt = up ? W'(q.cnt + 1'b1) : W'(q.cnt - 1'b1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q.cnt <= fcc_pkg::CNT_RST;
    else
      q <= d;
  end
endmodule

// ===== fcc_div.sv
// Programmable divider giving a one-cycle tick and a square wave.
`timescale 1ns/1ps
module fcc_div #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic en,
  input wire logic [W-1:0] div,
  // Results
  output logic tick,
  output logic square
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic sq;
  } fcc_div_s;
  fcc_div_s q, d;

  // The tick lasts one enabled step every div+1 steps.
  assign tick = en && (q.cnt >= div);
  assign square = q.sq;

  always_comb
  begin
    d = q;
    if (en)
    begin
      d.cnt = tick ? '0 : W'(q.cnt + 1'b1);
      if (tick)
        d.sq = !q.sq;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end
endmodule

// ===== fcc_field.sv
// Field-side model driving the counter's source and gate lines.
`timescale 1ns/1ps
module fcc_field #(
  parameter int NCH = 5
) (
  // Clock
  input wire logic aclk,
  // Field lines towards the counter
  output logic [NCH-1:0] src_iso,
  output logic [NCH-1:0] gate_iso,
  output logic [NCH-1:0] src_ttl_n,
  output logic [NCH-1:0] gate_ttl_n
);
  // =====================================================================
  // Idle: isolated lines off, TTL lines sit high since they are inverted.
  initial
  begin
    src_iso = '0;
    gate_iso = '0;
    src_ttl_n = '1;
    gate_ttl_n = '1;
  end
  // One source pulse, w clocks active then w idle; w sets the pace.
  task automatic pulse(input int k, input bit ttl, input int w);
    @(posedge aclk);
    if (ttl)
      src_ttl_n[k] <= 1'b0;
    else
      src_iso[k] <= 1'b1;
    repeat (w) @(posedge aclk);
    src_ttl_n[k] <= 1'b1;
    src_iso[k] <= 1'b0;
    repeat (w) @(posedge aclk);
  endtask
  task automatic gate(input int k, input bit v);
    @(posedge aclk);
    gate_iso[k] <= v;
  endtask
endmodule

// ===== fcc_pkg.sv
// Package of constants for the five-channel programmable counter.
// =====================================================================
// Notes on behaviour
// - Five independent counter channels, each sixteen bits wide.
// - Each channel counts up or down in plain binary, per its config.
// - A channel may take its steps from its lower neighbour's carry.
// - Counting runs only while the run bit and hardware gate allow.
// - Steps come from a selected external input or an internal source.
// - Wrap drives the output pin; it interrupts only when unmasked.
// - A programmable time reference is selectable as any count source.
// - Any input routes to any counter; gate level and edge selectable.
// - Five source and five gate inputs, isolated and TTL, are accepted.
// - One open-collector pin per channel shows its over- or underflow.
// - One more output gives a software-set frequency from the reference.
// - The identification register reads back a fixed module code.
package fcc_pkg;
  // =====================================================================
  // Register map, byte addresses on a 32-bit AXI4-Lite bus.
  localparam logic [7:0] ADDR_ID = 8'h00;
  localparam logic [7:0] ADDR_GCTRL = 8'h04;
  localparam logic [7:0] ADDR_STS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_TBDIV = 8'h10;
  localparam logic [7:0] ADDR_FDIV = 8'h14;
  localparam logic [7:0] ADDR_CH_BASE = 8'h20;
  localparam logic [7:0] ADDR_CH_END = 8'h6f;
  localparam logic [3:0] CH_CFG = 4'h0;
  localparam logic [3:0] CH_RLD = 4'h4;
  localparam logic [3:0] CH_CNT = 4'h8;
  // =====================================================================
  // Field positions.
  localparam int GCTRL_RUN_LSB = 0;
  localparam int GCTRL_CHAIN_LSB = 8;
  localparam int CFG_UP = 0;
  localparam int CFG_HWGATE = 1;
  localparam int CFG_GATE_HIGH = 2;
  localparam int CFG_FALL = 3;
  localparam int CFG_LEVEL_OUT = 4;
  localparam int CFG_SRC_LSB = 8;
  localparam int CFG_GSEL_LSB = 12;
  // Source numbers 0-4 are source pins, 5-9 gate pins, 10 and 11 internal.
  localparam logic [3:0] SRC_TB = 4'ha;
  localparam logic [3:0] SRC_FOUT = 4'hb;
  // =====================================================================
  // Reset values and timing.
  localparam logic [15:0] CFG_RST = 16'h0001;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam longint CLK_HZ = 125_000_000;
  localparam longint TB_HZ = 5_000_000;
  localparam logic [15:0] TB_DIV_RST = 16'(CLK_HZ / TB_HZ - 1);
  localparam logic [15:0] FDIV_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== fcc_top.sv
// Five-channel counter with AXI4-Lite registers, interrupts and outputs.
`timescale 1ns/1ps
module fcc_top #(
  parameter int NCH = 5,
  parameter int CW = 16,
  // Arbitrary neutral identification value.
  parameter logic [15:0] MODULE_ID = 16'h00a5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Field inputs, isolated active high, TTL active low
  input wire logic [NCH-1:0] src_iso,
  input wire logic [NCH-1:0] gate_iso,
  input wire logic [NCH-1:0] src_ttl_n,
  input wire logic [NCH-1:0] gate_ttl_n,
  // Open-collector outputs, pin low while enable is high
  output logic [NCH-1:0] cnt_out_o,
  output logic [NCH-1:0] cnt_out_oe,
  output logic fout_o,
  output logic fout_oe,
  // Interrupt
  output logic irq
);
  // =====================================================================
  // State.
  localparam int NLV = 2 * NCH + 2;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NCH-1:0] run;
    logic [NCH-1:0] chain;
    logic [NCH-1:0] sts;
    logic [NCH-1:0] mask;
    logic [15:0] tb_div;
    logic [15:0] fout_div;
    logic [NCH-1:0][15:0] cfg;
    logic [NCH-1:0][CW-1:0] rld;
    logic [NLV-1:0] lvl_prev;
    logic [NCH-1:0] out;
    logic fout;
  } fcc_top_s;

  fcc_top_s q, d;
  logic [NCH-1:0] ld;
  logic [CW-1:0] ld_val;
  logic [NCH-1:0] step;
  logic [NCH-1:0] carry;
  logic [NCH-1:0][CW-1:0] count;
  logic [NLV-1:0] lvl;
  logic tb_tick;
  logic fout_sq;

  // =====================================================================
  // Input conditioning and internal time reference.
  // The TTL inputs carry inverted levels and are ORed onto the isolated.
  assign lvl[NCH-1:0] = src_iso | ~src_ttl_n;
  assign lvl[2*NCH-1:NCH] = gate_iso | ~gate_ttl_n;
  assign lvl[NLV-2] = tb_tick;
  assign lvl[NLV-1] = fout_sq;

  fcc_div #(.W(16)) u_tb (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(1'b1),
    .div(q.tb_div),
    .tick(tb_tick),
    .square()
  );

  fcc_div #(.W(16)) u_fout (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(tb_tick),
    .div(q.fout_div),
    .tick(),
    .square(fout_sq)
  );

  // =====================================================================
  // Counter channels.
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      logic [3:0] src_sel;
      logic [3:0] gate_sel;
      logic cur;
      logic prv;
      logic edge_hit;
      logic src_step;
      logic gate_raw;
      logic gate_ok;
      logic chained;

      assign src_sel = q.cfg[gi][fcc_pkg::CFG_SRC_LSB +: 4];
      assign gate_sel = q.cfg[gi][fcc_pkg::CFG_GSEL_LSB +: 4];
      assign cur = (int'(src_sel) < NLV) ? lvl[src_sel] : 1'b0;
      assign prv = (int'(src_sel) < NLV) ? q.lvl_prev[src_sel] : 1'b0;
      // Edge select: falling when the bit is set, else rising.
      assign edge_hit = q.cfg[gi][fcc_pkg::CFG_FALL] ? (prv && !cur)
        : (cur && !prv);
      // The time reference is already a one-cycle tick, so no edge is taken.
      assign src_step = (src_sel == fcc_pkg::SRC_TB) ? tb_tick
        : edge_hit;
      assign gate_raw = (int'(gate_sel) < NLV) ? lvl[gate_sel] : 1'b0;
      assign gate_ok = !q.cfg[gi][fcc_pkg::CFG_HWGATE]
        || (gate_raw == q.cfg[gi][fcc_pkg::CFG_GATE_HIGH]);
      if (gi == 0)
      begin : g_first
        assign chained = 1'b0;
      end
      else
      begin : g_next
        assign chained = q.chain[gi] && carry[gi-1];
      end
      assign step[gi] = q.run[gi] && gate_ok
        && (q.chain[gi] ? chained : src_step);

      fcc_chan #(.W(CW)) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .step(step[gi]),
        .up(q.cfg[gi][fcc_pkg::CFG_UP]),
        .load(ld[gi]),
        .load_val(ld_val),
        .reload_val(q.rld[gi]),
        .count(count[gi]),
        .carry(carry[gi])
      );
    end
  endgenerate

  // =====================================================================
  // Helpers.
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  function automatic logic is_ch(input logic [7:0] a);
    return (a >= fcc_pkg::ADDR_CH_BASE) && (a <= fcc_pkg::ADDR_CH_END);
  endfunction

  // =====================================================================
  // Bus slave, register file, interrupts and outputs.
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  always_comb
  begin
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] wv;
    logic [31:0] rv;
    logic rerr;
    logic werr;
    int wc;
    int rc;
    d = q;
    ld = '0;
    wa = q.awaddr;
    ra = s_axi_araddr;
    wv = '0;
    rv = '0;
    rerr = 1'b0;
    werr = 1'b0;
    wc = 0;
    rc = 0;
    ld_val = '0;
    d.lvl_prev = lvl;

    // Channel events: sticky status, set wins over a clear below.
    for (int i = 0; i < NCH; i++)
    begin
      if (q.cfg[i][fcc_pkg::CFG_LEVEL_OUT])
        d.out[i] = carry[i] ? !q.out[i] : q.out[i];
      else
        d.out[i] = carry[i];
    end
    d.fout = fout_sq;

    // Write channel: take address and data in either order.
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      wc = int'(wa - fcc_pkg::ADDR_CH_BASE) >> 4;
      if (wa == fcc_pkg::ADDR_GCTRL)
      begin
        wv = merge({19'h0, q.chain, 3'h0, q.run}, q.wdata, q.wstrb);
        d.run = wv[fcc_pkg::GCTRL_RUN_LSB +: NCH];
        d.chain = wv[fcc_pkg::GCTRL_CHAIN_LSB +: NCH] & ~NCH'(1);
      end
      else if (wa == fcc_pkg::ADDR_STS)
      begin
        wv = merge('0, q.wdata, q.wstrb);
        d.sts = q.sts & ~wv[NCH-1:0];
      end
      else if (wa == fcc_pkg::ADDR_MASK)
      begin
        wv = merge({27'h0, q.mask}, q.wdata, q.wstrb);
        d.mask = wv[NCH-1:0];
      end
      else if (wa == fcc_pkg::ADDR_TBDIV)
      begin
        wv = merge({16'h0, q.tb_div}, q.wdata, q.wstrb);
        d.tb_div = wv[15:0];
      end
      else if (wa == fcc_pkg::ADDR_FDIV)
      begin
        wv = merge({16'h0, q.fout_div}, q.wdata, q.wstrb);
        d.fout_div = wv[15:0];
      end
      else if (is_ch(wa) && wa[3:0] == fcc_pkg::CH_CFG)
      begin
        wv = merge({16'h0, q.cfg[wc]}, q.wdata, q.wstrb);
        d.cfg[wc] = wv[15:0];
      end
      else if (is_ch(wa) && wa[3:0] == fcc_pkg::CH_RLD)
      begin
        wv = merge({16'h0, q.rld[wc]}, q.wdata, q.wstrb);
        d.rld[wc] = wv[CW-1:0];
      end
      else if (is_ch(wa) && wa[3:0] == fcc_pkg::CH_CNT)
      begin
        wv = merge({16'h0, count[wc]}, q.wdata, q.wstrb);
        ld[wc] = 1'b1;
        ld_val = wv[CW-1:0];
      end
      else if (wa != fcc_pkg::ADDR_ID)
        werr = 1'b1;
      d.bresp = werr ? fcc_pkg::RESP_SLVERR : fcc_pkg::RESP_OKAY;
    end
    d.sts = d.sts | carry;
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    // Read channel: one read at a time, answer on the following cycle.
    if (s_axi_arvalid && s_axi_arready)
    begin
      rc = int'(ra - fcc_pkg::ADDR_CH_BASE) >> 4;
      if (ra == fcc_pkg::ADDR_ID)
        rv = {16'h0, MODULE_ID};
      else if (ra == fcc_pkg::ADDR_GCTRL)
        rv = {19'h0, q.chain, 3'h0, q.run};
      else if (ra == fcc_pkg::ADDR_STS)
        rv = {27'h0, q.sts};
      else if (ra == fcc_pkg::ADDR_MASK)
        rv = {27'h0, q.mask};
      else if (ra == fcc_pkg::ADDR_TBDIV)
        rv = {16'h0, q.tb_div};
      else if (ra == fcc_pkg::ADDR_FDIV)
        rv = {16'h0, q.fout_div};
      else if (is_ch(ra) && ra[3:0] == fcc_pkg::CH_CFG)
        rv = {16'h0, q.cfg[rc]};
      else if (is_ch(ra) && ra[3:0] == fcc_pkg::CH_RLD)
        rv = {16'h0, q.rld[rc]};
      else if (is_ch(ra) && ra[3:0] == fcc_pkg::CH_CNT)
        rv = {16'h0, count[rc]};
      else
        rerr = 1'b1;
      d.rvalid = 1'b1;
      d.rdata = rv;
      d.rresp = rerr ? fcc_pkg::RESP_SLVERR : fcc_pkg::RESP_OKAY;
    end
    else if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.run <= '0;
      q.mask <= '0;
      q.tb_div <= fcc_pkg::TB_DIV_RST;
      q.fout_div <= fcc_pkg::FDIV_RST;
      for (int i = 0; i < NCH; i++)
      begin
        q.cfg[i] <= fcc_pkg::CFG_RST;
        q.rld[i] <= fcc_pkg::CNT_RST;
      end
    end
    else
      q <= d;
  end

  // =====================================================================
  // Pins and interrupt. Open collector: the pin is only ever pulled low.
  assign cnt_out_o = '0;
  assign cnt_out_oe = q.out;
  assign fout_o = 1'b0;
  assign fout_oe = q.fout;
  assign irq = |(q.sts & q.mask);
endmodule

// ===== fcc_top_monitor.sv
// Checker of the counter block's bus handshakes and output pins.
`timescale 1ns/1ps
module fcc_top_monitor #(
  parameter int NCH = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [NCH-1:0] cnt_out_o,
  input wire logic [NCH-1:0] cnt_out_oe,
  input wire logic fout_o,
  input wire logic fout_oe,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // =====================================================================
  // Pins and reset
  AST_PIN_LOW: assert property (cnt_out_o == '0 && !fout_o)
    else $error("Open-collector data pin not held low.");
  AST_RST_QUIET: assert property ($rose(aresetn) |->
    !s_axi_bvalid && !s_axi_rvalid && !irq && cnt_out_oe == '0 && !fout_oe)
    else $error("Outputs not quiet after reset.");
  // =====================================================================
  // Register bus
  AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("Read address ready wrong.");
  AST_R_LATENCY: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data late.");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data not held.");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response not held.");
  AST_B_BLOCKS: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("Write taken while response pending.");
  AST_B_LATENCY: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("Write response late.");
endmodule
bind fcc_top fcc_top_monitor #(.NCH(NCH)) fcc_top_monitor_inst (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cnt_out_o(cnt_out_o),
  .cnt_out_oe(cnt_out_oe), .fout_o(fout_o), .fout_oe(fout_oe), .irq(irq)
);

// ===== tb.sv
// Self-checking testbench of the five-channel counter.
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] ID = 16'h00a5; // Arbitrary value.
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, fout_o, fout_oe, irq;
  logic [4:0] src_iso, gate_iso, src_ttl_n, gate_ttl_n;
  logic [4:0] cnt_out_o, cnt_out_oe;
  int n_errors = 0;
  int n_tests = 0;
  int oe_cycles = 0;
  fcc_top #(.MODULE_ID(ID)) fcc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .src_iso(src_iso), .gate_iso(gate_iso), .src_ttl_n(src_ttl_n),
    .gate_ttl_n(gate_ttl_n), .cnt_out_o(cnt_out_o),
    .cnt_out_oe(cnt_out_oe), .fout_o(fout_o), .fout_oe(fout_oe), .irq(irq)
  );
  fcc_field fcc_field_inst (
    .aclk(aclk), .src_iso(src_iso), .gate_iso(gate_iso),
    .src_ttl_n(src_ttl_n), .gate_ttl_n(gate_ttl_n)
  );
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Active output cycles; pulse mode must give exactly one per event.
  always @(posedge aclk)
    oe_cycles <= oe_cycles + $countones(cnt_out_oe);
  // =====================================================================
  // Common tasks
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] ch_a(input int n, input logic [3:0] off);
    return fcc_pkg::ADDR_CH_BASE + 8'(16 * n) + 8'(off);
  endfunction
  // Entered just after a rising edge; returns one edge after the answer edge.
  task automatic bus(input bit we, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ah, wh, dh;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    for (i = 0; i < 40; i++)
    begin
      @(negedge aclk);
      ah = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      wh = s_axi_wvalid & s_axi_wready;
      dh = we ? s_axi_bvalid : s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = we ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ah)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (wh)
        s_axi_wvalid <= 1'b0;
      if (dh)
      begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        // An edge passes so a following call never reassigns in this step.
        @(posedge aclk);
        return;
      end
    end
    n_errors++;
    tally_and_finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd_data);
  endtask
  task automatic irq_is(input logic e);
    @(negedge aclk);
    chk("irq", 32'(e), 32'(irq));
    @(posedge aclk);
  endtask
  // =====================================================================
  // Scenarios
  task automatic t_reset_values;
    wr(fcc_pkg::ADDR_ID, 32'h0);
    chk("id write resp", 32'(fcc_pkg::RESP_OKAY), 32'(rd_resp));
    wr(8'h7c, 32'h0);
    chk("bad wr resp", 32'(fcc_pkg::RESP_SLVERR), 32'(rd_resp));
    rd("id", fcc_pkg::ADDR_ID, 32'(ID));
    rd("gctrl", fcc_pkg::ADDR_GCTRL, 32'h0);
    rd("mask", fcc_pkg::ADDR_MASK, 32'h0);
    rd("cfg0", ch_a(0, fcc_pkg::CH_CFG), 32'(fcc_pkg::CFG_RST));
    rd("tbdiv", fcc_pkg::ADDR_TBDIV, 32'(fcc_pkg::TB_DIV_RST));
    rd("unmapped", 8'h7c, 32'h0);
    chk("unmapped resp", 32'(fcc_pkg::RESP_SLVERR), 32'(rd_resp));
    irq_is(1'b0);
  endtask
  task automatic t_chain_overflow;
    wr(ch_a(0, fcc_pkg::CH_RLD), 32'h0010);
    wr(ch_a(0, fcc_pkg::CH_CNT), 32'hfffe);
    wr(fcc_pkg::ADDR_MASK, 32'h1);
    fcc_field_inst.pulse(0, 1'b0, 2);
    rd("stopped", ch_a(0, fcc_pkg::CH_CNT), 32'hfffe);
    wr(fcc_pkg::ADDR_GCTRL, 32'h0203);
    fcc_field_inst.pulse(0, 1'b0, 2);
    rd("up step", ch_a(0, fcc_pkg::CH_CNT), 32'hffff);
    fcc_field_inst.pulse(0, 1'b0, 1);
    rd("reload", ch_a(0, fcc_pkg::CH_CNT), 32'h0010);
    rd("chained", ch_a(1, fcc_pkg::CH_CNT), 32'h1);
    rd("status", fcc_pkg::ADDR_STS, 32'h1);
    chk("out pulses", 32'd1, 32'(oe_cycles));
    irq_is(1'b1);
    wr(fcc_pkg::ADDR_MASK, 32'h0);
    irq_is(1'b0);
    wr(fcc_pkg::ADDR_MASK, 32'h1);
    wr(fcc_pkg::ADDR_STS, 32'h1);
    irq_is(1'b0);
    rd("cleared", fcc_pkg::ADDR_STS, 32'h0);
  endtask
  // Channel 2: down, falling edge, TTL source 3, gate pin 2 active high.
  task automatic t_gate_down;
    wr(ch_a(2, fcc_pkg::CH_CFG), 32'h730e);
    wr(ch_a(2, fcc_pkg::CH_RLD), 32'h0abc);
    wr(ch_a(2, fcc_pkg::CH_CNT), 32'h1);
    wr(fcc_pkg::ADDR_GCTRL, 32'h4);
    fcc_field_inst.pulse(3, 1'b1, 2);
    rd("gate shut", ch_a(2, fcc_pkg::CH_CNT), 32'h1);
    fcc_field_inst.gate(2, 1'b1);
    fcc_field_inst.pulse(3, 1'b1, 2);
    rd("down step", ch_a(2, fcc_pkg::CH_CNT), 32'h0);
    fcc_field_inst.pulse(3, 1'b1, 2);
    rd("underflow", ch_a(2, fcc_pkg::CH_CNT), 32'h0abc);
    rd("status", fcc_pkg::ADDR_STS, 32'h4);
    chk("out pulses", 32'd2, 32'(oe_cycles));
  endtask
  function automatic logic pin(input int k);
    return (k < 5) ? cnt_out_oe[k] : fout_oe;
  endfunction
  // Clocks from one change of a pin (5 is fout) to the next.
  task automatic half_period(input string nm, input int k);
    int i;
    int n;
    logic v;
    @(negedge aclk);
    v = pin(k);
    for (i = 0; i < 100 && pin(k) === v; i++)
      @(negedge aclk);
    v = pin(k);
    n = 0;
    for (i = 0; i < 100 && pin(k) === v; i++)
    begin
      @(negedge aclk);
      n++;
    end
    chk(nm, 32'd10, 32'(n));
    @(posedge aclk);
  endtask
  // Tick every 5 clocks; fout and channel 4 (down, reload 1, level output,
  // time reference source) both change every 2 ticks: 10 clocks.
  task automatic t_fout;
    wr(fcc_pkg::ADDR_TBDIV, 32'h4);
    wr(fcc_pkg::ADDR_FDIV, 32'h1);
    wr(ch_a(4, fcc_pkg::CH_CFG), 32'h0a10);
    wr(ch_a(4, fcc_pkg::CH_RLD), 32'h1);
    wr(fcc_pkg::ADDR_GCTRL, 32'h10);
    half_period("fout half period", 5);
    half_period("ch4 half period", 4);
  endtask
  // Reset in mid-run with channel 4 counting: all must come back stopped.
  task automatic t_mid_reset;
    wr(fcc_pkg::ADDR_MASK, 32'h1f);
    irq_is(1'b1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd("gctrl after reset", fcc_pkg::ADDR_GCTRL, 32'h0);
    rd("mask after reset", fcc_pkg::ADDR_MASK, 32'h0);
    rd("cnt4", ch_a(4, fcc_pkg::CH_CNT), 32'(fcc_pkg::CNT_RST));
    irq_is(1'b0);
  endtask
  // =====================================================================
  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_values;
    t_chain_overflow;
    t_gate_down;
    t_fout;
    t_mid_reset;
    tally_and_finish;
  end
endmodule
